// ### deglitch_counter.sv
// per-channel persistence counter for one threshold direction
`timescale 1ns/1ps
module deglitch_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample,
  input wire logic violate,
  input wire logic [4:0] target,
  output logic fault,
  output logic pending
);

  logic [4:0] count_r;
  logic [4:0] count_nxt;
  logic hit;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // a clean sample restarts the run; saturation keeps the fault a single pulse
  assign hit = sample && violate && (count_r < target) && (count_r + 5'h01 >= target);
  assign count_nxt = !sample ? count_r :
                     !violate ? 5'h00 :
                     (count_r < target) ? count_r + 5'h01 : count_r;

  // count and fault pulse registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= 5'h00;
      fault <= 1'b0;
    end else begin
      count_r <= count_nxt;
      fault <= hit;
    end
  end

  // run in progress but not yet long enough to call a fault
  assign pending = (count_r != 5'h00) && (count_r < target);

endmodule // deglitch_counter

// ### fault_flag_critical_logger.sv
// fault flags, deglitch and one-shot critical fault logger
// Behaviour
// - violation must persist 2, 4, 8 or 16 conversions per two-bit deglitch field.
// - external fault pin pulled low while so configured sets overvoltage register bit 6.
// - bus alert asserted sets overvoltage register bit 7; write one clears it.
// - a fault starts a log only when its critical enable bit is set.
// - content field: 00 flags and ADC, 01 flags, 10 ADC, 11 nothing.
// - log-select bit 2 makes each external pin pull-low start a log.
// - undervoltage enable bits 0..5 map inputs one to six; bits 6,7 unused.
// - overvoltage enables: inputs 1-4 on bits 4-7, inputs 5-6 next register bits 0-1.
// - stop-control bit 5 makes external pull-low halt monitoring until enable toggle or retry.
// - the log occupies nine bytes at 200h through 208h.
// - after a log the memory locks and refuses later logs.
// - writing zero to lock register bit 1 unlocks and permits a new log.
// - stored ADC values are the eight most significant bits.
// - on violation hold the channel and count repeats before declaring a fault.
// - writing one clears a flag bit; writing zero leaves it.
// - a flag sets only when that channel's critical enable is set.
// - compare only the upper eight result bits against eight-bit limits.
`timescale 1ns/1ps
module fault_flag_critical_logger (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conv_valid,
  input wire logic [2:0] conv_channel,
  input wire logic [9:0] conv_result,
  input wire logic [7:0] ov_limit,
  input wire logic [7:0] uv_limit,
  input wire logic external_fault_pin_n,
  input wire logic shared_io_pin_six_is_ext,
  input wire logic alert_asserted,
  input wire logic enable_toggled,
  input wire logic retry_expired,
  output logic hold_channel,
  output logic monitor_stop,
  output logic [5:0] uv_fault,
  output logic [5:0] ov_fault,
  output logic log_written
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] uv_flags_r;
  logic [7:0] ov_flags_r;
  logic [7:0] log_sel_r;
  logic [7:0] uv_crit_r;
  logic [7:0] ov_crit_lo_r;
  logic [7:0] ov_crit_hi_r;
  logic [7:0] ext_stop_r;
  logic [7:0] deglitch_r;
  fault_log_pkg::log_state_t lock_r;
  fault_log_pkg::log_state_t lock_nxt;
  logic [7:0] log_mem_r [fault_log_pkg::LOG_DEPTH];
  logic [7:0] adc_r [fault_log_pkg::NUM_CH];
  logic stop_r;
  logic log_pulse_r;

  // ----------------------------------------------------------------
  // external fault pin synchroniser
  // ----------------------------------------------------------------
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;

  // the pin is asynchronous to clk; only ext_s2_r and later feed logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_prev_r <= 1'b1;
    end else begin
      ext_s1_r <= external_fault_pin_n;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // pin counts only while the shared pin is configured as external fault
  logic ext_low;
  logic ext_fall;
  assign ext_low = shared_io_pin_six_is_ext && !ext_s2_r;
  assign ext_fall = ext_low && ext_prev_r;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic wr_uv_flags;
  logic wr_ov_flags;
  logic wr_log_sel;
  logic wr_uv_crit;
  logic wr_ov_lo;
  logic wr_ov_hi;
  logic wr_ext_stop;
  logic wr_deglitch;
  logic wr_lock;
  logic in_log;
  logic [9:0] log_off;
  assign wr_uv_flags = reg_wr && (reg_addr == fault_log_pkg::OFS_UV_FLAGS);
  assign wr_ov_flags = reg_wr && (reg_addr == fault_log_pkg::OFS_OV_FLAGS);
  assign wr_log_sel = reg_wr && (reg_addr == fault_log_pkg::OFS_LOG_SEL);
  assign wr_uv_crit = reg_wr && (reg_addr == fault_log_pkg::OFS_UV_CRIT);
  assign wr_ov_lo = reg_wr && (reg_addr == fault_log_pkg::OFS_OV_CRIT_LO);
  assign wr_ov_hi = reg_wr && (reg_addr == fault_log_pkg::OFS_OV_CRIT_HI);
  assign wr_ext_stop = reg_wr && (reg_addr == fault_log_pkg::OFS_EXT_STOP);
  assign wr_deglitch = reg_wr && (reg_addr == fault_log_pkg::OFS_DEGLITCH);
  assign wr_lock = reg_wr && (reg_addr == fault_log_pkg::OFS_LOCK);
  assign in_log = (reg_addr >= fault_log_pkg::OFS_LOG_FIRST) &&
                  (reg_addr <= fault_log_pkg::OFS_LOG_LAST);
  assign log_off = reg_addr - fault_log_pkg::OFS_LOG_FIRST;

  // ----------------------------------------------------------------
  // comparison and deglitch per channel
  // ----------------------------------------------------------------
  logic [4:0] dg_target;
  logic [7:0] result_msb;
  logic [5:0] uv_pend;
  logic [5:0] ov_pend;
  logic [5:0] uv_en;
  logic [5:0] ov_en;
  assign dg_target = fault_log_pkg::DEGLITCH_BASE << deglitch_r[fault_log_pkg::DEGLITCH_LSB +: 2];
  assign result_msb = conv_result[9:2];
  assign uv_en = uv_crit_r[5:0];
  assign ov_en = {ov_crit_hi_r[1:0], ov_crit_lo_r[7:fault_log_pkg::OV_LO_SHIFT]};

  genvar ch;
  generate
    for (ch = 0; ch < fault_log_pkg::NUM_CH; ch++) begin : g_ch
      logic sel;
      assign sel = conv_valid && (conv_channel == 3'(ch));
      deglitch_counter u_uv (
        .clk(clk),
        .rst(rst),
        .sample(sel),
        .violate(result_msb < uv_limit),
        .target(dg_target),
        .fault(uv_fault[ch]),
        .pending(uv_pend[ch])
      );
      deglitch_counter u_ov (
        .clk(clk),
        .rst(rst),
        .sample(sel),
        .violate(result_msb > ov_limit),
        .target(dg_target),
        .fault(ov_fault[ch]),
        .pending(ov_pend[ch])
      );
      // latest 8-bit result kept for the log snapshot
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          adc_r[ch] <= fault_log_pkg::REG_RESET;
        end else if (sel) begin
          adc_r[ch] <= result_msb;
        end
      end
    end
  endgenerate

  // the sequencer stays on the channel while any run is in progress
  assign hold_channel = |{uv_pend, ov_pend};

  // ----------------------------------------------------------------
  // fault flags: set wins over a simultaneous write-one clear
  // ----------------------------------------------------------------
  logic [5:0] uv_crit_hit;
  logic [5:0] ov_crit_hit;
  logic ext_crit_hit;
  logic [7:0] uv_flags_nxt;
  logic [7:0] ov_flags_nxt;
  logic [7:0] uv_clr;
  logic [7:0] ov_clr;
  logic [7:0] ov_set;
  assign uv_crit_hit = uv_fault & uv_en;
  assign ov_crit_hit = ov_fault & ov_en;
  assign ext_crit_hit = ext_fall && log_sel_r[fault_log_pkg::EXT_LOG_EN_BIT];
  assign uv_clr = wr_uv_flags ? reg_wdata : 8'h00;
  assign ov_clr = wr_ov_flags ? reg_wdata : 8'h00;
  assign ov_set = {alert_asserted, ext_low, ov_crit_hit};
  assign uv_flags_nxt = ((uv_flags_r & ~uv_clr) | {2'b00, uv_crit_hit}) &
                        fault_log_pkg::FLAG_MASK;
  assign ov_flags_nxt = (ov_flags_r & ~ov_clr) | ov_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uv_flags_r <= fault_log_pkg::REG_RESET;
      ov_flags_r <= fault_log_pkg::REG_RESET;
    end else begin
      uv_flags_r <= uv_flags_nxt;
      ov_flags_r <= ov_flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers; unused bits are held at zero, except deglitch_r, which keeps all eight written bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      log_sel_r <= fault_log_pkg::REG_RESET;
      uv_crit_r <= fault_log_pkg::REG_RESET;
      ov_crit_lo_r <= fault_log_pkg::REG_RESET;
      ov_crit_hi_r <= fault_log_pkg::REG_RESET;
      ext_stop_r <= fault_log_pkg::REG_RESET;
      deglitch_r <= fault_log_pkg::REG_RESET;
    end else begin
      if (wr_log_sel) log_sel_r <= reg_wdata & fault_log_pkg::LOG_SEL_MASK;
      if (wr_uv_crit) uv_crit_r <= reg_wdata & fault_log_pkg::UV_CRIT_MASK;
      if (wr_ov_lo) ov_crit_lo_r <= reg_wdata & fault_log_pkg::OV_LO_MASK;
      if (wr_ov_hi) ov_crit_hi_r <= reg_wdata & fault_log_pkg::OV_HI_MASK;
      if (wr_ext_stop) ext_stop_r <= reg_wdata & fault_log_pkg::EXT_STOP_MASK;
      if (wr_deglitch) deglitch_r <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // monitoring stop on external fault
  // ----------------------------------------------------------------
  // a new pull-low in the same cycle as a release keeps monitoring stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_r <= 1'b0;
    end else if (ext_fall && ext_stop_r[fault_log_pkg::EXT_STOP_BIT]) begin
      stop_r <= 1'b1;
    end else if (enable_toggled || retry_expired) begin
      stop_r <= 1'b0;
    end
  end
  assign monitor_stop = stop_r;

  // ----------------------------------------------------------------
  // log writer and lock
  // ----------------------------------------------------------------
  logic [1:0] content;
  logic trigger;
  logic do_log;
  logic keep_flags;
  logic keep_adc;
  assign content = log_sel_r[1:0];
  assign trigger = (|uv_crit_hit) || (|ov_crit_hit) || ext_crit_hit;
  // a lock that is already set refuses the trigger outright
  assign do_log = trigger && (content != fault_log_pkg::CONTENT_OFF) &&
                  (lock_r == fault_log_pkg::LOG_OPEN);
  assign keep_flags = (content == fault_log_pkg::CONTENT_BOTH) ||
                      (content == fault_log_pkg::CONTENT_FLAGS);
  assign keep_adc = (content == fault_log_pkg::CONTENT_BOTH) ||
                    (content == fault_log_pkg::CONTENT_ADC);

  // log write wins over a same-cycle unlock write
  always_comb begin
    lock_nxt = lock_r;
    if (do_log) begin
      lock_nxt = fault_log_pkg::LOG_LOCKED;
    end else if (wr_lock) begin
      lock_nxt = reg_wdata[fault_log_pkg::LOCK_BIT] ? fault_log_pkg::LOG_LOCKED :
                 fault_log_pkg::LOG_OPEN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_r <= fault_log_pkg::LOG_OPEN;
      log_pulse_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      log_pulse_r <= do_log;
    end
  end
  assign log_written = log_pulse_r;

  // log bytes: index 0 stays reserved at zero, unselected content stays zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < fault_log_pkg::LOG_DEPTH; i++) begin
        log_mem_r[i] <= fault_log_pkg::REG_RESET;
      end
    end else if (do_log) begin
      log_mem_r[fault_log_pkg::LOG_UV_IDX] <= keep_flags ? {2'b00, uv_crit_hit} : 8'h00;
      log_mem_r[fault_log_pkg::LOG_OV_IDX] <= keep_flags ?
                                             {1'b0, ext_crit_hit, ov_crit_hit} : 8'h00;
      for (int i = 0; i < fault_log_pkg::NUM_CH; i++) begin
        log_mem_r[fault_log_pkg::LOG_ADC_IDX + i] <= keep_adc ? adc_r[i] : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port: registered data one cycle after reg_rd
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] lock_view;
  assign lock_view = (lock_r == fault_log_pkg::LOG_LOCKED) ? 8'h02 : 8'h00;
  assign rd_mux = (reg_addr == fault_log_pkg::OFS_UV_FLAGS) ? uv_flags_r :
                  (reg_addr == fault_log_pkg::OFS_OV_FLAGS) ? ov_flags_r :
                  (reg_addr == fault_log_pkg::OFS_LOG_SEL) ? log_sel_r :
                  (reg_addr == fault_log_pkg::OFS_UV_CRIT) ? uv_crit_r :
                  (reg_addr == fault_log_pkg::OFS_OV_CRIT_LO) ? ov_crit_lo_r :
                  (reg_addr == fault_log_pkg::OFS_OV_CRIT_HI) ? ov_crit_hi_r :
                  (reg_addr == fault_log_pkg::OFS_EXT_STOP) ? ext_stop_r :
                  (reg_addr == fault_log_pkg::OFS_DEGLITCH) ? deglitch_r :
                  (reg_addr == fault_log_pkg::OFS_LOCK) ? lock_view :
                  in_log ? log_mem_r[log_off[3:0]] : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule // fault_flag_critical_logger

// ### fault_flag_critical_logger_asserts.sv
// port checker for the fault flag and critical fault logger
`timescale 1ns/1ps
module fault_flag_critical_logger_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_valid,
  input wire logic [2:0] conv_channel,
  input wire logic [9:0] conv_result,
  input wire logic [7:0] ov_limit,
  input wire logic [7:0] uv_limit,
  input wire logic external_fault_pin_n,
  input wire logic enable_toggled,
  input wire logic retry_expired,
  input wire logic hold_channel,
  input wire logic monitor_stop,
  input wire logic [5:0] uv_fault,
  input wire logic [5:0] ov_fault,
  input wire logic log_written
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // -----------------------------------------------------------
  // deglitch and fault pulses
  // -----------------------------------------------------------
  // a pulse must name the channel of the sample just taken
  wire logic rel_w = enable_toggled | retry_expired;
  a_uv_fault_cause: assert property (|uv_fault |-> $past(conv_valid) &&
    ($past(conv_result[9:2]) < $past(uv_limit)) && (uv_fault == (6'h01 << $past(conv_channel))))
    else $error("uv fault without a low sample");
  a_ov_fault_cause: assert property (|ov_fault |-> $past(conv_valid) &&
    ($past(conv_result[9:2]) > $past(ov_limit)) && (ov_fault == (6'h01 << $past(conv_channel))))
    else $error("ov fault without a high sample");
  a_fault_deglitched: assert property ((|uv_fault || |ov_fault) |-> $past(hold_channel))
    else $error("fault on a single sample");
  a_uv_no_repeat: assert property ((uv_fault & $past(uv_fault)) == 6'h00)
    else $error("uv fault pulse longer than one cycle");
  a_hold_on_violation: assert property (conv_valid && !monitor_stop && conv_channel < 3'h6 &&
    conv_result[9:2] < uv_limit |=> hold_channel || (|uv_fault))
    else $error("channel not held after violation");
  // -----------------------------------------------------------
  // monitoring stop and log pulse
  // -----------------------------------------------------------
  a_stop_holds: assert property (monitor_stop && !rel_w |=> monitor_stop)
    else $error("monitor stop dropped without release");
  a_stop_release: assert property (external_fault_pin_n [*5] ##0 rel_w |=> !monitor_stop)
    else $error("monitor stop kept after release");
  a_stop_cause: assert property ($rose(monitor_stop) |-> !$past(external_fault_pin_n, 2) ||
    !$past(external_fault_pin_n, 3) || !$past(external_fault_pin_n, 4))
    else $error("monitor stop without pin low");
  a_log_single: assert property (log_written |=> !log_written)
    else $error("log pulse repeated");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  c_uv_fault: cover property (|uv_fault);
  c_log: cover property (log_written);
  c_stop: cover property ($rose(monitor_stop));
endmodule // fault_flag_critical_logger_asserts

bind fault_flag_critical_logger fault_flag_critical_logger_asserts chk (.clk(clk), .rst(rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
  .conv_channel(conv_channel), .conv_result(conv_result), .ov_limit(ov_limit),
  .uv_limit(uv_limit), .external_fault_pin_n(external_fault_pin_n),
  .enable_toggled(enable_toggled), .retry_expired(retry_expired),
  .hold_channel(hold_channel), .monitor_stop(monitor_stop), .uv_fault(uv_fault),
  .ov_fault(ov_fault), .log_written(log_written));

// ### fault_flag_critical_logger_test.sv
// self-checking bench for the fault flag and critical fault logger
`timescale 1ns/1ps
module fault_flag_critical_logger_test;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, conv_valid = 1'b0;
  logic [9:0] reg_addr = 10'h000, conv_result = 10'h000;
  logic [7:0] reg_wdata = 8'h00, ov_limit = 8'hC0, uv_limit = 8'h80, reg_rdata, rv;
  logic [2:0] conv_channel = 3'h0;
  logic external_fault_pin_n = 1'b1, shared_io_pin_six_is_ext = 1'b0, alert_asserted = 1'b0;
  logic enable_toggled = 1'b0, retry_expired = 1'b0, hold_channel, monitor_stop, log_written;
  logic [5:0] uv_fault, ov_fault, u, o;
  int error_cnt = 0, num_checks = 0, cycles = 0, log_cnt = 0;
  // samples: low gives 40h, high gives FFh, inside gives A0h
  localparam logic [9:0] UV_BAD = 10'h103, OV_BAD = 10'h3FC, GOOD = 10'h280;
  localparam logic [9:0] TA [9] = '{10'h06D, 10'h06E, 10'h06F, 10'h070, 10'h072, 10'h074,
    10'h071, 10'h3FF, 10'h204};
  localparam logic [7:0] TE [9] = '{8'h07, 8'h3F, 8'hF0, 8'h03, 8'h20, 8'hFF, 8'h00, 8'h00, 8'h00};

  fault_flag_critical_logger dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_result(conv_result),
    .ov_limit(ov_limit), .uv_limit(uv_limit), .external_fault_pin_n(external_fault_pin_n),
    .shared_io_pin_six_is_ext(shared_io_pin_six_is_ext), .alert_asserted(alert_asserted),
    .enable_toggled(enable_toggled), .retry_expired(retry_expired),
    .hold_channel(hold_channel), .monitor_stop(monitor_stop), .uv_fault(uv_fault),
    .ov_fault(ov_fault), .log_written(log_written));

  initial begin
    forever #10 clk = ~clk;
  end
  // log pulses are counted here so no scenario can miss the one-cycle pulse;
  // sampled at the falling edge, where the registered pulse has settled
  always @(negedge clk) begin
    cycles++;
    if (log_written === 1'b1) log_cnt++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  // -----------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------
  task summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [9:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    rv = reg_rdata;
  endtask
  task rdchk(input logic [9:0] a, input logic [7:0] exp);
    rd(a);
    chk(rv, exp);
  endtask
  // n back-to-back samples; the fault pulse is caught in the cycle after the last
  task run(input logic [2:0] ch, input logic [9:0] res, input int n);
    @(negedge clk);
    conv_valid = 1'b1;
    conv_channel = ch;
    conv_result = res;
    repeat (n) @(negedge clk);
    conv_valid = 1'b0;
    u = uv_fault;
    o = ov_fault;
    repeat (2) @(negedge clk);
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task t_regs;
    for (int i = 0; i < 9; i++) begin
      rdchk(TA[i], 8'h00);
      wr(TA[i], 8'hFF);
      rdchk(TA[i], TE[i]);
      wr(TA[i], 8'h00);
    end
  endtask
  task t_deglitch;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = 2 << c;
      wr(10'h074, 8'(c << 5));
      run(3'h0, UV_BAD, n - 1);
      chk({2'h0, u}, 8'h00);
      chk({7'h0, hold_channel}, 8'h01);
      run(3'h0, GOOD, 1);
      run(3'h0, UV_BAD, n);
      chk({2'h0, u}, 8'h01);
      chk({2'h0, o}, 8'h00);
      chk({7'h0, hold_channel}, 8'h00);
      run(3'h0, GOOD, 1);
    end
    wr(10'h074, 8'h00);
    rdchk(10'h01B, 8'h00);
    chk(8'(log_cnt), 8'h00);
  endtask
  task t_log;
    wr(10'h06E, 8'h01);
    run(3'h0, UV_BAD, 2);
    chk(8'(log_cnt), 8'h01);
    rdchk(10'h01B, 8'h01);
    rdchk(10'h200, 8'h00);
    rdchk(10'h201, 8'h01);
    rdchk(10'h202, 8'h00);
    rdchk(10'h203, 8'h40);
    rd(10'h08C);
    chk({7'h0, rv[1]}, 8'h01);
    run(3'h0, GOOD, 1);
    run(3'h0, 10'h0FF, 2);
    chk(8'(log_cnt), 8'h01);
    rdchk(10'h203, 8'h40);
    wr(10'h01B, 8'h00);
    rdchk(10'h01B, 8'h01);
    wr(10'h01B, 8'h01);
    rdchk(10'h01B, 8'h00);
    // unlocked again, then overvoltage with flags only
    wr(10'h08C, 8'h00);
    rd(10'h08C);
    chk({7'h0, rv[1]}, 8'h00);
    wr(10'h06D, 8'h01);
    wr(10'h070, 8'h01);
    wr(10'h06F, 8'h10);
    run(3'h4, OV_BAD, 2);
    chk({2'h0, o}, 8'h10);
    chk(8'(log_cnt), 8'h02);
    rdchk(10'h202, 8'h10);
    rdchk(10'h201, 8'h00);
    rdchk(10'h207, 8'h00);
    run(3'h4, GOOD, 1);
    run(3'h0, OV_BAD, 2);
    rdchk(10'h01C, 8'h11);
    // logging turned off, then adc values only
    wr(10'h08C, 8'h00);
    wr(10'h06D, 8'h03);
    run(3'h0, GOOD, 1);
    run(3'h0, OV_BAD, 2);
    chk(8'(log_cnt), 8'h02);
    wr(10'h06D, 8'h02);
    run(3'h0, GOOD, 1);
    run(3'h0, OV_BAD, 2);
    chk(8'(log_cnt), 8'h03);
    rdchk(10'h202, 8'h00);
    rdchk(10'h203, 8'hFF);
    rdchk(10'h207, 8'hA0);
    wr(10'h01C, 8'hFF);
  endtask
  // sel picks which release pulse ends the stop
  task t_ext(input logic sel);
    int l0;
    l0 = log_cnt;
    wr(10'h08C, 8'h00);
    wr(10'h06D, 8'h04);
    wr(10'h072, 8'h20);
    shared_io_pin_six_is_ext = 1'b1;
    external_fault_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h0, monitor_stop}, 8'h01);
    chk(8'(log_cnt - l0), 8'h01);
    rd(10'h01C);
    chk(rv & 8'h40, 8'h40);
    rdchk(10'h202, 8'h40);
    external_fault_pin_n = 1'b1;
    repeat (4) @(negedge clk);
    wr(10'h01C, 8'h40);
    rd(10'h01C);
    chk(rv & 8'h40, 8'h00);
    if (sel) retry_expired = 1'b1;
    else enable_toggled = 1'b1;
    @(negedge clk);
    retry_expired = 1'b0;
    enable_toggled = 1'b0;
    chk({7'h0, monitor_stop}, 8'h00);
    // with the stop bit clear the pin must not halt monitoring
    wr(10'h072, 8'h00);
    external_fault_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h0, monitor_stop}, 8'h00);
    external_fault_pin_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task t_alert;
    @(negedge clk);
    alert_asserted = 1'b1;
    @(negedge clk);
    alert_asserted = 1'b0;
    rd(10'h01C);
    chk(rv & 8'h80, 8'h80);
    wr(10'h01C, 8'h80);
    rd(10'h01C);
    chk(rv & 8'h80, 8'h00);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_deglitch();
    t_log();
    t_ext(1'b0);
    t_ext(1'b1);
    t_alert();
    summarize();
  end
endmodule // fault_flag_critical_logger_test

// ### fault_log_pkg.sv
// shared constants for the fault-flag and critical-fault logging block
package fault_log_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int LOG_DEPTH = 9;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] OFS_UV_FLAGS = 10'h01B;
  localparam logic [9:0] OFS_OV_FLAGS = 10'h01C;
  localparam logic [9:0] OFS_LOG_SEL = 10'h06D;
  localparam logic [9:0] OFS_UV_CRIT = 10'h06E;
  localparam logic [9:0] OFS_OV_CRIT_LO = 10'h06F;
  localparam logic [9:0] OFS_OV_CRIT_HI = 10'h070;
  localparam logic [9:0] OFS_CRIT_SPARE = 10'h071;
  localparam logic [9:0] OFS_EXT_STOP = 10'h072;
  localparam logic [9:0] OFS_DEGLITCH = 10'h074;
  localparam logic [9:0] OFS_LOCK = 10'h08C;
  localparam logic [9:0] OFS_LOG_FIRST = 10'h200;
  localparam logic [9:0] OFS_LOG_LAST = 10'h208;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EXT_FLAG_BIT = 6;
  localparam int ALERT_FLAG_BIT = 7;
  localparam int EXT_LOG_EN_BIT = 2;
  localparam int EXT_STOP_BIT = 5;
  localparam int DEGLITCH_LSB = 5;
  localparam int LOCK_BIT = 1;
  localparam int OV_LO_SHIFT = 4;
  localparam int LOG_UV_IDX = 1;
  localparam int LOG_OV_IDX = 2;
  localparam int LOG_ADC_IDX = 3;

  // ----------------------------------------------------------------
  // field encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CONTENT_BOTH = 2'h0;
  localparam logic [1:0] CONTENT_FLAGS = 2'h1;
  localparam logic [1:0] CONTENT_ADC = 2'h2;
  localparam logic [1:0] CONTENT_OFF = 2'h3;
  localparam logic [4:0] DEGLITCH_BASE = 5'h02;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LOG_SEL_MASK = 8'h07;
  localparam logic [7:0] UV_CRIT_MASK = 8'h3F;
  localparam logic [7:0] OV_LO_MASK = 8'hF0;
  localparam logic [7:0] OV_HI_MASK = 8'h03;
  localparam logic [7:0] EXT_STOP_MASK = 8'h20;
  localparam logic [7:0] FLAG_MASK = 8'h3F;

  typedef enum logic [0:0] {
    LOG_OPEN = 1'b0,
    LOG_LOCKED = 1'b1
  } log_state_t;

endpackage
